// *** logic/cvf_defines.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * current and voltage acquisition filter.
 * Assumes: included by its bare name into the filter module and the testbench.
 */
`ifndef CVF_DEFINES_SVH
`define CVF_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CVF_A_RUN   5'h00
`define CVF_A_CFG   5'h01
`define CVF_A_GTH   5'h02
`define CVF_A_GAIN  5'h03
`define CVF_A_STAT  5'h04
`define CVF_A_OFSI  5'h05
`define CVF_A_VSEL  5'h06
`define CVF_A_FLT   5'h07
`define CVF_A_VRES  5'h08
`define CVF_A_IRH   5'h09
`define CVF_A_IRL   5'h0A
`define CVF_A_GCV   5'h0B
`define CVF_A_GCI   5'h0C
`define CVF_A_OFSV  5'h0D

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CVF_B_IRUN  0
`define CVF_B_VRUN  1
`define CVF_B_OPDET 0
`define CVF_B_ICOMP 1
`define CVF_B_VOLTAGE_COMP_ENABLE 2
`define CVF_B_AUTOG 3
`define CVF_B_VCHP  4
`define CVF_B_LPON  5
`define CVF_B_IIE   6
`define CVF_B_VIE   7
`define CVF_B_OPEN  0
`define CVF_B_GCHG  1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CVF_R_CFG   8'h08
`define CVF_R_GTH   8'hF0
`define CVF_R_GC    10'h200
`define CVF_R_FLT   10'h000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CVF_CLK_HZ   20000000
`define CVF_DECIM_HZ 512000
`define CVF_TICK_DIV (`CVF_CLK_HZ / `CVF_DECIM_HZ)
`define CVF_LAT_BASE 8'h04
`define CVF_LAT_IIR  8'h03
`define CVF_LAT_AVG  8'h03
`define CVF_DF_LOG   6
`define CVF_DSEL_MAX 3'h4

`endif

// *** logic/cvf_pkg.sv ***
/*
 * Types of the current and voltage acquisition filter.
 * Assumes: nothing beyond the defines header.
 */
package cvf_pkg;
    typedef enum logic [2:0] {
        FIR_IDLE = 3'b001,
        FIR_RUN  = 3'b010,
        FIR_DONE = 3'b100
    } cvf_fir_t;
endpackage : cvf_pkg

// *** logic/cvf_filter.sv ***
/*
 * Current and voltage acquisition filter: gain control, compensation, IIR,
 * sinc3 decimation, chop averaging, shared FIR and result formatting.
 * Assumes: modulator bits, amplifier level and pins are asynchronous;
 * register master on mclk_in.
 */
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "cvf_defines.svh"

module cvf_filter import cvf_pkg::*; #(
    parameter int DIV  = `CVF_TICK_DIV,
    parameter int TAPS = 16
) (
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    input  wire logic [4:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    input  wire logic        i_bit_in,
    input  wire logic        v_bit_in,
    input  wire logic [4:0]  amp_level_in,
    input  wire logic        shunt_open_in,
    input  wire logic        low_power_in,
    output logic      [1:0]  gain_out,
    output logic      [3:0]  vsel_out,
    output logic             i_chop_out,
    output logic             v_chop_out,
    output logic             i_irq_out,
    output logic             v_irq_out
);
    if (DIV < 1 || DIV > 64 || TAPS != 16) begin : g_bad
        $error("cvf_filter: unsupported parameter");
    end

    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        hit = (a == r);
    endfunction : hit

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    logic        [5:0]  div_reg;
    logic        [9:0]  dcnt_reg;
    logic        [1:0]  chop_reg;
    logic        [1:0]  bit_s1, bit_s2;
    logic        [4:0]  lvl_s1, lvl_s2;
    logic        [1:0]  pin_s1, pin_s2;
    logic        [1:0]  run_reg;
    logic        [7:0]  cfg_reg;
    logic        [7:0]  gth_reg;
    logic        [9:0]  flt_reg;
    logic        [1:0]  gain_reg;
    logic               gchg_reg, open_reg;
    logic        [7:0]  ofsi_reg [4];
    logic        [7:0]  ofsv_reg;
    logic        [9:0]  gc_reg [2];
    logic        [3:0]  vsel_reg;
    logic        [15:0] coef_reg [16];
    logic        [15:0] vres_reg;
    logic        [23:0] ires_reg;
    logic        [15:0] rdata_reg;
    logic signed [16:0] iir_reg [2];
    logic signed [47:0] in1_reg [2], in2_reg [2], in3_reg [2];
    logic signed [47:0] dl1_reg [2], dl2_reg [2], dl3_reg [2];
    logic signed [17:0] samp_reg [2];
    logic signed [17:0] hist_reg [2][3];
    logic signed [17:0] line_reg [2][16];
    logic signed [39:0] acc_reg [2];
    logic        [3:0]  k_reg;
    logic               go_reg;
    logic        [7:0]  hold_reg;
    logic               i_chop_reg, v_chop_reg, i_irq_reg, v_irq_reg;
    cvf_fir_t           st_reg;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire        wr_run  = wr_in && hit(addr_in, `CVF_A_RUN);
    wire        wr_stat = wr_in && hit(addr_in, `CVF_A_STAT);
    wire        wr_gain = wr_in && hit(addr_in, `CVF_A_GAIN);
    wire        auto_g  = cfg_reg[`CVF_B_AUTOG];
    wire        lp_on   = cfg_reg[`CVF_B_LPON];
    wire [2:0]  alpha   = flt_reg[2:0];
    wire [2:0]  dsel    = (flt_reg[5:3] > `CVF_DSEL_MAX) ? `CVF_DSEL_MAX : flt_reg[5:3];
    wire [9:0]  df_m1   = 10'((11'h040 << dsel) - 11'h001);
    wire [4:0]  sh      = 5'(3 * (`CVF_DF_LOG + dsel));
    wire [3:0]  ntap    = lp_on ? flt_reg[9:6] : 4'h0;
    wire        tick    = (div_reg == 6'(DIV - 1));
    wire        dtick   = tick && (dcnt_reg == df_m1);
    wire        phase   = chop_reg[1];
    wire [4:0]  up_th   = {1'b0, gth_reg[7:4]} + 5'h01;
    wire [4:0]  dn_th   = {1'b0, gth_reg[3:0]};
    wire        g_dn    = auto_g && (lvl_s2 >= up_th) && (gain_reg != 2'h0);
    wire        g_up    = auto_g && !g_dn && (lvl_s2 < dn_th) && (gain_reg != 2'h3);
    wire [7:0]  lat     = `CVF_LAT_BASE + ((alpha != 3'h0) ? `CVF_LAT_IIR : 8'h00)
                          + `CVF_LAT_AVG + (lp_on ? 8'(ntap) + 8'h01 : 8'h00);
    wire [1:0]  chop_on = {cfg_reg[`CVF_B_VCHP], 1'b1};
    wire [1:0]  comp_on = {cfg_reg[`CVF_B_VOLTAGE_COMP_ENABLE], cfg_reg[`CVF_B_ICOMP]};

    // ----------------------------------------------------------------
    // channel datapath
    // ----------------------------------------------------------------
    logic signed [16:0] x_w [2];
    logic signed [16:0] iir_w [2];
    logic signed [47:0] c3_w [2];
    logic signed [17:0] dem_w [2];
    logic signed [17:0] avg_w [2];
    logic signed [17:0] fir_w [2];
    logic        [9:0]  gcv;
    logic        [7:0]  ofv;
    logic signed [17:0] dif;
    logic signed [47:0] c1, c2, scl;
    logic signed [19:0] sum;

    always_comb begin
        gcv = '0;
        ofv = '0;
        dif = '0;
        c1 = '0;
        c2 = '0;
        scl = '0;
        sum = '0;
        for (int c = 0; c < 2; c++) begin
            gcv = comp_on[c] ? gc_reg[c] : `CVF_R_GC;
            ofv = !comp_on[c] ? 8'h00 : (c == 0) ? ofsi_reg[gain_reg] : ofsv_reg;
            x_w[c] = ((bit_s2[c] ^ (chop_on[c] && phase)) ? $signed({2'b00, gcv, 5'h00})
                     : -$signed({2'b00, gcv, 5'h00})) + 17'($signed(ofv));
            dif = 18'(x_w[c]) - 18'(iir_reg[c]);
            iir_w[c] = iir_reg[c] + 17'(dif >>> alpha);
            c1 = in3_reg[c] - dl1_reg[c];
            c2 = c1 - dl2_reg[c];
            c3_w[c] = c2 - dl3_reg[c];
            scl = c3_w[c] >>> sh;
            dem_w[c] = scl[17:0];
            sum = 20'(samp_reg[c]) + 20'(hist_reg[c][0]) + 20'(hist_reg[c][1]) + 20'(hist_reg[c][2]);
            avg_w[c] = 18'(sum >>> 2);
            fir_w[c] = lp_on ? 18'(acc_reg[c] >>> 15) : line_reg[c][0];
        end
    end

    wire signed [17:0] vfin = fir_w[1];
    wire signed [17:0] ifin = fir_w[0];
    // full-scale stream lands on the clamp
    wire signed [19:0] vfmt = {vfin, 2'b00};
    wire signed [19:0] ifmt = {ifin, 2'b00};
    wire [15:0] vclamp = vfmt[19] ? 16'h0000 : ((vfmt[18:16] != 3'h0) ? 16'hFFFF : vfmt[15:0]);
    wire [16:0] iclamp = (ifmt[19:16] == {4{ifmt[16]}}) ? ifmt[16:0] :
                         ifmt[19] ? 17'h10000 : 17'h0FFFF;
    wire        emit   = (st_reg == FIR_DONE) && (hold_reg == 8'h00);

    // ----------------------------------------------------------------
    // synchronisers, timing, control
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        bit_s1 <= {v_bit_in, i_bit_in};
        bit_s2 <= bit_s1;
        lvl_s1 <= amp_level_in;
        lvl_s2 <= lvl_s1;
        pin_s1 <= {low_power_in, shunt_open_in};
        pin_s2 <= pin_s1;
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in || wr_run) begin
            div_reg <= '0;
            dcnt_reg <= '0;
            chop_reg <= '0;
        end else begin
            div_reg <= tick ? 6'h00 : div_reg + 6'h01;
            if (tick) dcnt_reg <= dtick ? 10'h000 : dcnt_reg + 10'h001;
            if (dtick) chop_reg <= chop_reg + 2'h1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            run_reg <= '0;
            cfg_reg <= `CVF_R_CFG;
            gth_reg <= `CVF_R_GTH;
            flt_reg <= `CVF_R_FLT;
            gain_reg <= '0;
            gchg_reg <= 1'b0;
            open_reg <= 1'b0;
            ofsv_reg <= '0;
            vsel_reg <= '0;
            for (int i = 0; i < 4; i++) ofsi_reg[i] <= '0;
            for (int i = 0; i < 2; i++) gc_reg[i] <= `CVF_R_GC;
            for (int i = 0; i < 16; i++) coef_reg[i] <= '0;
        end else begin
            if (wr_run) run_reg <= wdata_in[1:0];
            else if (pin_s2[1]) run_reg[`CVF_B_VRUN] <= 1'b0;
            if (wr_in && hit(addr_in, `CVF_A_CFG)) cfg_reg <= wdata_in[7:0];
            if (wr_in && hit(addr_in, `CVF_A_GTH)) gth_reg <= wdata_in[7:0];
            if (wr_in && hit(addr_in, `CVF_A_FLT)) flt_reg <= wdata_in[9:0];
            if (wr_in && hit(addr_in, `CVF_A_VSEL)) vsel_reg <= wdata_in[3:0];
            if (wr_in && hit(addr_in, `CVF_A_OFSV)) ofsv_reg <= wdata_in[7:0];
            if (wr_in && hit(addr_in, `CVF_A_OFSI)) ofsi_reg[gain_reg] <= wdata_in[7:0];
            if (wr_in && hit(addr_in, `CVF_A_GCI)) gc_reg[0] <= wdata_in[9:0];
            if (wr_in && hit(addr_in, `CVF_A_GCV)) gc_reg[1] <= wdata_in[9:0];
            if (wr_in && addr_in[4]) coef_reg[addr_in[3:0]] <= wdata_in;
            if (wr_gain && !auto_g) gain_reg <= wdata_in[1:0];
            else if (tick && g_dn) gain_reg <= gain_reg - 2'h1;
            else if (tick && g_up) gain_reg <= gain_reg + 2'h1;
            if (tick && (g_dn || g_up)) gchg_reg <= 1'b1;
            else if (wr_stat && wdata_in[`CVF_B_GCHG]) gchg_reg <= 1'b0;
            if (cfg_reg[`CVF_B_OPDET] && pin_s2[0]) open_reg <= 1'b1;
            else if (wr_stat && wdata_in[`CVF_B_OPEN]) open_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // filter chain
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!rstn_in || wr_run) begin
            go_reg <= 1'b0;
            st_reg <= FIR_IDLE;
            k_reg <= '0;
            hold_reg <= rstn_in ? lat : 8'h00;
            for (int c = 0; c < 2; c++) begin
                iir_reg[c] <= '0;
                in1_reg[c] <= '0;
                in2_reg[c] <= '0;
                in3_reg[c] <= '0;
                dl1_reg[c] <= '0;
                dl2_reg[c] <= '0;
                dl3_reg[c] <= '0;
                samp_reg[c] <= '0;
                acc_reg[c] <= '0;
                for (int j = 0; j < 3; j++) hist_reg[c][j] <= '0;
                for (int j = 0; j < 16; j++) line_reg[c][j] <= '0;
            end
        end else begin
            go_reg <= dtick;
            for (int c = 0; c < 2; c++) begin
                if (tick) begin
                    iir_reg[c] <= iir_w[c];
                    in1_reg[c] <= in1_reg[c] + 48'(iir_reg[c]);
                    in2_reg[c] <= in2_reg[c] + in1_reg[c];
                    in3_reg[c] <= in3_reg[c] + in2_reg[c];
                end
                if (dtick) begin
                    dl1_reg[c] <= in3_reg[c];
                    dl2_reg[c] <= in3_reg[c] - dl1_reg[c];
                    dl3_reg[c] <= in3_reg[c] - dl1_reg[c] - dl2_reg[c];
                    samp_reg[c] <= dem_w[c];
                    hist_reg[c][0] <= samp_reg[c];
                    hist_reg[c][1] <= hist_reg[c][0];
                    hist_reg[c][2] <= hist_reg[c][1];
                end
            end
            unique case (st_reg)
                FIR_IDLE: if (go_reg) begin
                    st_reg <= FIR_RUN;
                    k_reg <= '0;
                    for (int c = 0; c < 2; c++) begin
                        acc_reg[c] <= '0;
                        line_reg[c][0] <= avg_w[c];
                        for (int j = 1; j < 16; j++) line_reg[c][j] <= line_reg[c][j-1];
                    end
                end
                FIR_RUN: begin
                    for (int c = 0; c < 2; c++)
                        if (k_reg <= ntap)
                            acc_reg[c] <= acc_reg[c] + 40'($signed(coef_reg[k_reg]) * line_reg[c][k_reg]);
                    k_reg <= k_reg + 4'h1;
                    if (k_reg == 4'hF) st_reg <= FIR_DONE;
                end
                FIR_DONE: begin
                    st_reg <= FIR_IDLE;
                    if (hold_reg != 8'h00) hold_reg <= hold_reg - 8'h01;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // results, outputs, read port
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            vres_reg <= '0;
            ires_reg <= '0;
            i_irq_reg <= 1'b0;
            v_irq_reg <= 1'b0;
            i_chop_reg <= 1'b0;
            v_chop_reg <= 1'b0;
        end else begin
            i_irq_reg <= emit && run_reg[`CVF_B_IRUN] && cfg_reg[`CVF_B_IIE];
            v_irq_reg <= emit && run_reg[`CVF_B_VRUN] && cfg_reg[`CVF_B_VIE];
            if (emit && run_reg[`CVF_B_VRUN]) vres_reg <= vclamp;
            if (emit && run_reg[`CVF_B_IRUN]) ires_reg <= {gain_reg, 5'h00, iclamp};
            i_chop_reg <= phase && run_reg[`CVF_B_IRUN];
            v_chop_reg <= phase && run_reg[`CVF_B_VRUN] && chop_on[1];
        end
    end

    logic [15:0] rd_next;
    always_comb begin
        rd_next = 16'h0000;
        if (addr_in[4]) rd_next = coef_reg[addr_in[3:0]];
        else
            unique case (addr_in)
                `CVF_A_RUN:  rd_next = {14'h0000, run_reg};
                `CVF_A_CFG:  rd_next = {8'h00, cfg_reg};
                `CVF_A_GTH:  rd_next = {8'h00, gth_reg};
                `CVF_A_GAIN: rd_next = {14'h0000, gain_reg};
                `CVF_A_STAT: rd_next = {14'h0000, gchg_reg, open_reg};
                `CVF_A_OFSI: rd_next = {8'h00, ofsi_reg[gain_reg]};
                `CVF_A_VSEL: rd_next = {12'h000, vsel_reg};
                `CVF_A_FLT:  rd_next = {6'h00, flt_reg};
                `CVF_A_VRES: rd_next = vres_reg;
                `CVF_A_IRH:  rd_next = {8'h00, ires_reg[23:16]};
                `CVF_A_IRL:  rd_next = ires_reg[15:0];
                `CVF_A_GCV:  rd_next = {6'h00, gc_reg[1]};
                `CVF_A_GCI:  rd_next = {6'h00, gc_reg[0]};
                `CVF_A_OFSV: rd_next = {8'h00, ofsv_reg};
                default:     rd_next = 16'h0000;
            endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) rdata_reg <= '0;
        else rdata_reg <= rd_in ? rd_next : 16'h0000;
    end

    assign rdata_out  = rdata_reg;
    assign gain_out   = gain_reg;
    assign vsel_out   = vsel_reg;
    assign i_chop_out = i_chop_reg;
    assign v_chop_out = v_chop_reg;
    assign i_irq_out  = i_irq_reg;
    assign v_irq_out  = v_irq_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_run_write;
        wr_run;
    endsequence
    sequence s_restarted;
        ##1 (div_reg == 6'h00 && dcnt_reg == 10'h000 && st_reg == FIR_IDLE && hold_reg == $past(lat));
    endsequence

    a_sync_start: assert property (s_run_write |-> s_restarted) else $error("restart not aligned");
    a_vchop_off: assert property (!chop_on[1] |=> !v_chop_out) else $error("voltage chop while off");
    a_open_set: assert property (cfg_reg[0] && pin_s2[0] |=> open_reg) else $error("open not set");
    a_gain_step: assert property (!$past(wr_gain) && $changed(gain_reg)
        |-> (gain_reg == $past(gain_reg) + 2'h1 || gain_reg == $past(gain_reg) - 2'h1))
        else $error("gain jumped");
    a_gain_flag: assert property (tick && (g_dn || g_up) |=> gchg_reg && gain_reg != $past(gain_reg))
        else $error("gain flag missing");
    a_manual_gain: assert property (wr_gain && !auto_g |=> gain_reg == $past(wdata_in[1:0]))
        else $error("manual gain lost");
    a_hold_off: assert property (i_irq_out || v_irq_out |-> $past(hold_reg) == 8'h00)
        else $error("result during latency");
    a_irq_pulse: assert property (emit && run_reg[0] && cfg_reg[6] |=> i_irq_out ##1 !i_irq_out)
        else $error("current irq wrong");
    a_vpwr_stop: assert property (pin_s2[1] && !wr_run |=> !run_reg[1]) else $error("voltage kept running");
endmodule : cvf_filter

// *** verification/cvf_mod_model.sv ***
/* modulator pair model: one density loop per channel, chopped at the input
   assumes mclk_in is the filter clock and the chopper phases come from the filter */
`timescale 1ns/100ps
module cvf_mod_model (
    input  wire logic       mclk_in,
    input  wire logic       i_chop_in,
    input  wire logic       v_chop_in,
    input  wire logic [7:0] i_dens_in,
    input  wire logic [7:0] v_dens_in,
    output logic            i_bit_out,
    output logic            v_bit_out
);
    // ----------------------------------------------------------------
    // density loops
    // ----------------------------------------------------------------
    logic [8:0] i_acc_reg = 9'h000;
    logic [8:0] v_acc_reg = 9'h000;
    always_ff @(posedge mclk_in) begin
        i_acc_reg <= {1'b0, i_acc_reg[7:0]} + {1'b0, i_dens_in};
        v_acc_reg <= {1'b0, v_acc_reg[7:0]} + {1'b0, v_dens_in};
    end
    // analog chopper ahead of the modulator swaps the input
    assign i_bit_out = ((i_dens_in == 8'hFF) | i_acc_reg[8]) ^ i_chop_in;
    assign v_bit_out = ((v_dens_in == 8'hFF) | v_acc_reg[8]) ^ v_chop_in;
endmodule : cvf_mod_model

// *** verification/tb.sv ***
/* register bus tests of the acquisition filter
   assumes DIV of 4, so one decimated sample every 256 clocks at DF 64 */
`timescale 1ns/100ps
`include "cvf_defines.svh"
module tb;
    logic mclk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [4:0] addr_in = 5'h00;
    logic [15:0] wdata_in = 16'h0000, rdata_out, rv;
    logic i_bit, v_bit, shunt_open_in = 1'b0, low_power_in = 1'b0;
    logic [4:0] amp_level_in = 5'h05;
    logic [7:0] i_dens = 8'h80, v_dens = 8'h80;
    logic [1:0] gain_out;
    logic [3:0] vsel_out;
    logic i_chop_out, v_chop_out, i_irq_out, v_irq_out;
    int err_count = 0, compares = 0, n, ti, tv;
    cvf_filter #(.DIV(4), .TAPS(16)) i_dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .i_bit_in(i_bit), .v_bit_in(v_bit),
        .amp_level_in(amp_level_in), .shunt_open_in(shunt_open_in),
        .low_power_in(low_power_in), .gain_out(gain_out), .vsel_out(vsel_out),
        .i_chop_out(i_chop_out), .v_chop_out(v_chop_out), .i_irq_out(i_irq_out),
        .v_irq_out(v_irq_out));
    cvf_mod_model i_mod (.mclk_in(mclk_in), .i_chop_in(i_chop_out), .v_chop_in(v_chop_out),
        .i_dens_in(i_dens), .v_dens_in(v_dens), .i_bit_out(i_bit), .v_bit_out(v_bit));
    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        rd_in <= 1'b0;
        @(posedge mclk_in);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        addr_in <= a;
        rd_in <= 1'b1;
        wr_in <= 1'b0;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        @(posedge mclk_in);
        rv = rdata_out;
    endtask : rd
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic tick(input int c);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        repeat (c) @(posedge mclk_in);
    endtask : tick
    task automatic wirq();
        logic pi, pv;
        n = 0; ti = 0; tv = 0; pi = i_chop_out; pv = v_chop_out;
        while (i_irq_out !== 1'b1 && n < 9000) begin
            tick(1);
            n++;
            ti += (i_chop_out !== pi);
            tv += (v_chop_out !== pv);
            pi = i_chop_out;
            pv = v_chop_out;
        end
        if (n >= 9000) err_count++;
    endtask : wirq
    task automatic stop_test();
        if (err_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    // ----------------------------------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------------------------------
    initial begin
        forever #25 mclk_in = ~mclk_in;
    end
    initial begin
        repeat (60000) @(posedge mclk_in);
        err_count++;
        stop_test();
    end
    initial begin
        tick(2);
        rstn_in <= 1'b1;
        tick(1);
        rd(`CVF_A_CFG); chk("cfg", 16'h0008, rv);
        rd(`CVF_A_GTH); chk("gth", 16'h00F0, rv);
        rd(`CVF_A_GCI); chk("gci", 16'h0200, rv);
        wr(`CVF_A_GTH, 16'h0074); wr(5'h0E, 16'h0055);
        rd(`CVF_A_GTH); chk("gth", 16'h0074, rv);
        rd(5'h0E); chk("free", 16'h0000, rv);
        amp_level_in <= 5'h03; tick(80); chk("gain up", 16'h0003, {14'h0, gain_out});
        rd(`CVF_A_STAT); chk("gchg", 16'h0001, {15'h0, rv[1]});
        amp_level_in <= 5'h08; tick(80); chk("gain dn", 16'h0000, {14'h0, gain_out});
        amp_level_in <= 5'h04; wr(`CVF_A_GAIN, 16'h0002); tick(8);
        chk("gain hold", 16'h0000, {14'h0, gain_out});
        wr(`CVF_A_CFG, 16'h0000); wr(`CVF_A_GAIN, 16'h0002); tick(1);
        chk("gain man", 16'h0002, {14'h0, gain_out});
        for (int g = 0; g < 4; g++) begin
            wr(`CVF_A_GAIN, 16'(g)); wr(`CVF_A_OFSI, 16'(8'h10 + g));
        end
        for (int g = 0; g < 4; g++) begin
            wr(`CVF_A_GAIN, 16'(g)); rd(`CVF_A_OFSI); chk("ofs", 16'(8'h10 + g), {8'h0, rv[7:0]});
        end
        wr(`CVF_A_VSEL, 16'h0008); tick(1); chk("vsel", 16'h0008, {12'h0, vsel_out});
        wr(`CVF_A_CFG, 16'h0001); shunt_open_in <= 1'b1; tick(8);
        wr(`CVF_A_STAT, 16'h0003); rd(`CVF_A_STAT); chk("open", 16'h0001, {15'h0, rv[0]});
        wr(`CVF_A_CFG, 16'h0000); tick(8); wr(`CVF_A_STAT, 16'h0003);
        rd(`CVF_A_STAT); chk("open off", 16'h0000, rv);
        i_dens <= 8'hFF; v_dens <= 8'hFF;
        wr(`CVF_A_GAIN, 16'h0001); wr(`CVF_A_CFG, 16'h00C0); wr(`CVF_A_RUN, 16'h0003);
        wirq(); chk("lat", 16'h0001, 16'((n >= 7 * 256) && (n <= 9 * 256 + 64)));
        chk("sync", 16'h0001, {15'h0, v_irq_out});
        chk("chop", 16'h0001, {15'h0, (ti == 4) && (tv == 0)});
        tick(1); wirq(); chk("rate", 16'(256), 16'(n + 1));
        rd(`CVF_A_VRES); chk("vmax", 16'hFFFF, rv);
        rd(`CVF_A_IRL); chk("imax lo", 16'hFFFF, rv);
        rd(`CVF_A_IRH); chk("imax hi", 16'h0040, {8'h0, rv[7:0]});
        i_dens <= 8'h00; v_dens <= 8'h00; tick(14 * 256);
        rd(`CVF_A_VRES); chk("vmin", 16'h0000, rv);
        rd(`CVF_A_IRL); chk("imin lo", 16'h0000, rv);
        rd(`CVF_A_IRH); chk("imin hi", 16'h0041, {8'h0, rv[7:0]});
        low_power_in <= 1'b1; tick(300); wirq();
        chk("lp v", 16'h0000, {15'h0, v_irq_out | v_chop_out});
        rd(`CVF_A_RUN); chk("lp run", 16'h0001, {14'h0, rv[1:0]});
        low_power_in <= 1'b0; v_dens <= 8'hFF; tick(4);
        wr(5'h10, 16'h4000);
        wr(`CVF_A_CFG, 16'h00F0); wr(`CVF_A_RUN, 16'h0003);
        wirq(); chk("resync", 16'h0001, {15'h0, v_irq_out});
        chk("vchop", 16'h0001, {15'h0, tv == 4});
        chk("fir lat", 16'h0001, 16'((n >= 8 * 256 + 64) && (n <= 9 * 256 + 64)));
        rd(`CVF_A_VRES); chk("fir v", 16'h8000, rv);
        rd(`CVF_A_IRL); chk("fir i", 16'h8000, rv);
        wr(`CVF_A_FLT, 16'h0009); wr(`CVF_A_RUN, 16'h0003);
        wirq(); chk("iir lat", 16'h0001, 16'((n >= 11 * 512 + 64) && (n <= 12 * 512 + 64)));
        tick(1); wirq(); chk("rate df", 16'(512), 16'(n + 1));
        stop_test();
    end
endmodule : tb
